// >>> src/ucpc_cfg.svh
`ifndef UCPC_CFG_SVH
`define UCPC_CFG_SVH
// register offsets on the 3-bit host address
`define UCPC_OFS_DATA 3'h0
`define UCPC_OFS_IER 3'h1
`define UCPC_OFS_EFR 3'h2
`define UCPC_OFS_MCR 3'h4
`define UCPC_OFS_MSR 3'h6
// modem control fields
`define UCPC_MCR_RTS 1
`define UCPC_MCR_OUT 3
`define UCPC_MCR_LOOP 4
// enhanced feature fields
`define UCPC_EFR_AUTO_RTS 6
// modem status fields
`define UCPC_MSR_RING_EDGE 2
`define UCPC_MSR_RING 6
// interrupt enable / pending fields
`define UCPC_INT_RX_DATA 0
`define UCPC_INT_TX_SPACE 1
`define UCPC_INT_RX_ERR 2
`define UCPC_INT_MODEM 3
// reset values
`define UCPC_MCR_RST 8'h00
`define UCPC_IER_RST 8'h00
`define UCPC_EFR_RST 8'h00
// pin filter: three flops, change once stage two and three agree
`define UCPC_SYNC_DEPTH 3
`endif

// >>> src/ucpc_pkg.sv
package ucpc_pkg;
   typedef enum logic [1:0] {
      UCPC_IDLE = 2'h0,
      UCPC_READ = 2'h1,
      UCPC_WRITE = 2'h2
   } ucpc_strobe_t;
   typedef logic [7:0] ucpc_byte_t;
endpackage

// >>> src/ucpc_top.sv
`timescale 1ns/1ps
`include "ucpc_cfg.svh"
module ucpc_top #(
   parameter int LEVEL_W = 7,
   parameter int FIFO_DEPTH = 64
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic channel_a_select_n,
   input wire logic reg_read_strobe_n,
   input wire logic reg_write_strobe_n,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic channel_a_irq_out,
   output logic channel_a_irq_oe,
   output logic channel_a_user_out_n,
   input wire logic channel_a_ring_ind_n,
   output logic rts_n,
   input wire logic serial_rx_pin,
   output logic serial_tx_pin,
   input wire logic tx_serial_bit,
   output logic rx_serial_bit,
   input wire logic [7:0] rx_hold_data,
   output logic [7:0] tx_hold_data,
   output logic tx_hold_write,
   output logic rx_hold_read,
   input wire logic rx_error,
   input wire logic [LEVEL_W-1:0] rx_level,
   input wire logic [LEVEL_W-1:0] tx_level,
   input wire logic [LEVEL_W-1:0] rx_trigger,
   input wire logic [LEVEL_W-1:0] tx_trigger,
   input wire logic [LEVEL_W-1:0] rts_halt_level,
   input wire logic [LEVEL_W-1:0] rts_resume_level,
   output logic channel_a_rx_dma_ready_n,
   output logic channel_a_tx_dma_ready_n
);
   localparam int SW = 16;
   localparam logic [LEVEL_W-1:0] DEPTH_L = LEVEL_W'(FIFO_DEPTH);

   // pin filter stages: cs, rd, wr, ring, rx, addr, data
   logic [SW-1:0] pin_raw;
   logic [SW-1:0] sync_s1;
   logic [SW-1:0] sync_s2;
   logic [SW-1:0] sync_s3;
   logic [SW-1:0] pin_f;
   logic [SW-1:0] next_pin_f;
   ucpc_pkg::ucpc_strobe_t strobe;
   logic rd_prev;
   logic wr_prev;
   logic ring_prev;
   logic cs_f;
   logic rd_f;
   logic wr_f;
   logic ring_n_f;
   logic rx_f;
   logic [2:0] addr_f;
   logic [7:0] din_f;
   logic rd_fall;
   logic wr_rise;
   logic ring_rise;
   logic wr_sel;
   ucpc_pkg::ucpc_byte_t modem_control_reg;
   ucpc_pkg::ucpc_byte_t interrupt_enable_reg;
   ucpc_pkg::ucpc_byte_t enhanced_feature_reg;
   ucpc_pkg::ucpc_byte_t modem_status_reg;
   ucpc_pkg::ucpc_byte_t read_mux;
   logic ring_delta;
   logic [3:0] pending;
   logic auto_room;
   logic [LEVEL_W-1:0] tx_free;

   assign pin_raw = {channel_a_select_n, reg_read_strobe_n, reg_write_strobe_n,
                     channel_a_ring_ind_n, serial_rx_pin, reg_addr, data_in};
   assign {cs_f, rd_f, wr_f, ring_n_f, rx_f, addr_f, din_f} = pin_f;

   // a bit of the filtered view moves only when stages two and three agree
   always_comb begin
      for (int i = 0; i < SW; i++) begin
         next_pin_f[i] = (sync_s2[i] == sync_s3[i]) ? sync_s3[i] : pin_f[i];
      end
   end

   // idle strobes high so reset release never looks like an edge
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sync_s1 <= 16'hFFFF;
         sync_s2 <= 16'hFFFF;
         sync_s3 <= 16'hFFFF;
         pin_f <= 16'hFFFF;
      end else begin
         sync_s1 <= pin_raw;
         sync_s2 <= sync_s1;
         sync_s3 <= sync_s2;
         pin_f <= next_pin_f;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_prev <= 1'b1;
         wr_prev <= 1'b1;
         ring_prev <= 1'b1;
      end else begin
         rd_prev <= rd_f;
         wr_prev <= wr_f;
         ring_prev <= ring_n_f;
      end
   end

   assign rd_fall = rd_prev && !rd_f && !cs_f;
   assign wr_rise = !wr_prev && wr_f;
   // addr and data are held through the strobe, so the filtered copy is valid
   assign wr_sel = wr_rise && !cs_f;
   assign ring_rise = !ring_prev && ring_n_f;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         strobe <= ucpc_pkg::UCPC_IDLE;
      end else begin
         case (strobe)
            ucpc_pkg::UCPC_IDLE: begin
               if (!cs_f && !rd_f) begin
                  strobe <= ucpc_pkg::UCPC_READ;
               end else if (!cs_f && !wr_f) begin
                  strobe <= ucpc_pkg::UCPC_WRITE;
               end
            end
            ucpc_pkg::UCPC_READ: begin
               if (rd_f || cs_f) begin
                  strobe <= ucpc_pkg::UCPC_IDLE;
               end
            end
            ucpc_pkg::UCPC_WRITE: begin
               if (wr_f) begin
                  strobe <= ucpc_pkg::UCPC_IDLE;
               end
            end
            default: strobe <= ucpc_pkg::UCPC_IDLE;
         endcase
      end
   end

   // control registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         modem_control_reg <= `UCPC_MCR_RST;
         interrupt_enable_reg <= `UCPC_IER_RST;
         enhanced_feature_reg <= `UCPC_EFR_RST;
      end else if (wr_sel) begin
         case (addr_f)
            `UCPC_OFS_IER: interrupt_enable_reg <= din_f;
            `UCPC_OFS_EFR: enhanced_feature_reg <= din_f;
            `UCPC_OFS_MCR: modem_control_reg <= din_f;
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_hold_write <= 1'b0;
         tx_hold_data <= 8'h00;
      end else begin
         tx_hold_write <= wr_sel && (addr_f == `UCPC_OFS_DATA);
         if (wr_sel && (addr_f == `UCPC_OFS_DATA)) begin
            tx_hold_data <= din_f;
         end
      end
   end

   // ring edge flag: an edge in the clearing read cycle survives
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ring_delta <= 1'b0;
      end else if (ring_rise) begin
         ring_delta <= 1'b1;
      end else if (rd_fall && addr_f == `UCPC_OFS_MSR) begin
         ring_delta <= 1'b0;
      end
   end

   always_comb begin
      modem_status_reg = 8'h00;
      modem_status_reg[`UCPC_MSR_RING] = !ring_n_f;
      modem_status_reg[`UCPC_MSR_RING_EDGE] = ring_delta;
   end

   always_comb begin
      case (addr_f)
         `UCPC_OFS_DATA: read_mux = rx_hold_data;
         `UCPC_OFS_IER: read_mux = interrupt_enable_reg;
         `UCPC_OFS_EFR: read_mux = enhanced_feature_reg;
         `UCPC_OFS_MCR: read_mux = modem_control_reg;
         `UCPC_OFS_MSR: read_mux = modem_status_reg;
         default: read_mux = 8'h00;
      endcase
   end

   // data latched at the falling edge, held for the whole strobe
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         data_out <= 8'h00;
         data_oe <= 1'b0;
         rx_hold_read <= 1'b0;
      end else begin
         if (rd_fall) begin
            data_out <= read_mux;
         end
         data_oe <= !rd_f && !cs_f;
         rx_hold_read <= rd_fall && (addr_f == `UCPC_OFS_DATA);
      end
   end

   assign pending[`UCPC_INT_RX_DATA] = (rx_level != '0);
   assign pending[`UCPC_INT_TX_SPACE] = (tx_level == '0);
   assign pending[`UCPC_INT_RX_ERR] = rx_error;
   assign pending[`UCPC_INT_MODEM] = ring_delta;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         channel_a_irq_out <= 1'b0;
         channel_a_irq_oe <= 1'b0;
         channel_a_user_out_n <= 1'b1;
      end else begin
         channel_a_irq_out <= |(pending & interrupt_enable_reg[3:0]);
         channel_a_irq_oe <= modem_control_reg[`UCPC_MCR_OUT];
         channel_a_user_out_n <= !modem_control_reg[`UCPC_MCR_OUT];
      end
   end
   // hysteresis between halt and resume levels
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         auto_room <= 1'b1;
      end else if (rx_level >= rts_halt_level) begin
         auto_room <= 1'b0;
      end else if (rx_level <= rts_resume_level) begin
         auto_room <= 1'b1;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rts_n <= 1'b1;
      end else begin
         rts_n <= !(modem_control_reg[`UCPC_MCR_RTS] &&
                    (!enhanced_feature_reg[`UCPC_EFR_AUTO_RTS] || auto_room));
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         serial_tx_pin <= 1'b1;
         rx_serial_bit <= 1'b1;
      end else if (modem_control_reg[`UCPC_MCR_LOOP]) begin
         serial_tx_pin <= 1'b1;
         rx_serial_bit <= tx_serial_bit;
      end else begin
         serial_tx_pin <= tx_serial_bit;
         rx_serial_bit <= rx_f;
      end
   end
   assign tx_free = DEPTH_L - tx_level;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         channel_a_rx_dma_ready_n <= 1'b1;
         channel_a_tx_dma_ready_n <= 1'b0;
      end else begin
         channel_a_rx_dma_ready_n <= !((rx_level >= rx_trigger) ||
                                       (rx_level != '0));
         channel_a_tx_dma_ready_n <= !((tx_free >= tx_trigger) ||
                                       (tx_level == '0));
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence ring_edge_s;
      ring_rise && !(rd_fall && addr_f == `UCPC_OFS_MSR);
   endsequence
   sequence mcr_out_set_s;
      wr_sel && addr_f == `UCPC_OFS_MCR && din_f[`UCPC_MCR_OUT];
   endsequence
   irq_gate_a: assert property (!modem_control_reg[`UCPC_MCR_OUT] |=> !channel_a_irq_oe)
      else $error("irq driven with output bit clear");
   out_pair_a: assert property (channel_a_irq_oe != channel_a_user_out_n)
      else $error("irq enable and user output disagree");
   mcr_out_a: assert property (mcr_out_set_s |=> ##1 channel_a_irq_oe && !channel_a_user_out_n)
      else $error("output bit write not reflected");
   ring_flag_a: assert property (ring_edge_s |=> ring_delta ##0 modem_status_reg[2])
      else $error("ring edge not flagged");
   ring_irq_a: assert property ((ring_edge_s and (interrupt_enable_reg[`UCPC_INT_MODEM]
      && !ring_prev)) |-> ##2 channel_a_irq_out)
      else $error("modem status interrupt missing");
   ring_level_a: assert property (rd_fall && addr_f == `UCPC_OFS_MSR
      |=> data_out[`UCPC_MSR_RING] == !$past(ring_n_f))
      else $error("ring level not readable");
   rts_manual_a: assert property (!enhanced_feature_reg[`UCPC_EFR_AUTO_RTS]
      && $stable(modem_control_reg) |=> rts_n == !$past(modem_control_reg[1]))
      else $error("rts does not follow control bit");
   loop_tx_a: assert property ($past(modem_control_reg[`UCPC_MCR_LOOP]) |-> serial_tx_pin)
      else $error("tx pin active in loop-back");
   loop_rx_a: assert property (modem_control_reg[`UCPC_MCR_LOOP]
      |=> rx_serial_bit == $past(tx_serial_bit))
      else $error("loop-back path broken");
   rx_ready_a: assert property (rx_level == '0 && rx_trigger != '0
      |=> channel_a_rx_dma_ready_n)
      else $error("rx ready low with empty fifo");
   tx_ready_a: assert property (tx_level == '0 |=> !channel_a_tx_dma_ready_n)
      else $error("tx ready high with empty fifo");
   one_write_a: assert property (wr_sel |=> !wr_sel [*2])
      else $error("write edge taken twice");
   cs_gate_a: assert property (cs_f |-> !wr_sel && !rd_fall)
      else $error("access without chip select");
   read_data_a: assert property (rd_fall && addr_f == `UCPC_OFS_MCR
      |=> data_out == $past(modem_control_reg))
      else $error("read data not latched");
   write_state_a: assert property (wr_sel |-> strobe == ucpc_pkg::UCPC_WRITE)
      else $error("write taken outside write state");
endmodule

// >>> sim/ucpc_host.sv
`timescale 1ns/1ps
module ucpc_host (
   input wire logic ref_clk,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic [2:0] addr,
   output logic [7:0] dout,
   input wire logic [7:0] din,
   input wire logic oe
);
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      addr = 3'h0;
      dout = 8'h00;
   end
   // strobe held 4 clocks, chip select held 5 more, then 4 idle: the pin filter passes a level held 2 and lags 4
   task automatic put(input logic [2:0] a, input logic [7:0] d, input logic sel_n);
      @(posedge ref_clk) #2;
      addr = a;
      dout = d;
      cs_n = sel_n;
      wr_n = 1'b0;
      repeat (4) @(posedge ref_clk);
      #2 wr_n = 1'b1;
      repeat (5) @(posedge ref_clk);
      #2 cs_n = 1'b1;
      dout = ~d; // released bus shows no stale value
      repeat (4) @(posedge ref_clk);
      #2;
   endtask
   task automatic get(input logic [2:0] a, output logic [7:0] d);
      int n;
      @(posedge ref_clk) #2;
      addr = a;
      cs_n = 1'b0;
      rd_n = 1'b0;
      n = 0;
      while (oe !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         n++;
      end
      d = (oe === 1'b1) ? din : 8'hXX;
      #2 rd_n = 1'b1;
      cs_n = 1'b1;
      repeat (6) @(posedge ref_clk);
      #2;
   endtask
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`include "ucpc_cfg.svh"
module tb_top;
   logic ref_clk, rst, ring_n, rx_pin, tx_bit, rx_error;
   logic cs_n, rd_n, wr_n, data_oe, irq, irq_oe, user_n, rts_n, tx_pin, rx_bit;
   logic tx_wr, rx_rd, rx_rdy_n, tx_rdy_n;
   logic [2:0] addr;
   logic [6:0] rx_level, tx_level, rx_trig, tx_trig, halt, resume;
   logic [7:0] bus_in, data_out, rx_hold, tx_data, got;
   int errors, checks, cycles, n_tx, n_rd;
   ucpc_host host (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
      .dout(bus_in), .din(data_out), .oe(data_oe));
   ucpc_top uut (.ref_clk(ref_clk), .rst(rst), .channel_a_select_n(cs_n),
      .reg_read_strobe_n(rd_n), .reg_write_strobe_n(wr_n), .reg_addr(addr),
      .data_in(bus_in), .data_out(data_out), .data_oe(data_oe), .channel_a_irq_out(irq),
      .channel_a_irq_oe(irq_oe), .channel_a_user_out_n(user_n),
      .channel_a_ring_ind_n(ring_n), .rts_n(rts_n), .serial_rx_pin(rx_pin),
      .serial_tx_pin(tx_pin), .tx_serial_bit(tx_bit), .rx_serial_bit(rx_bit),
      .rx_hold_data(rx_hold), .tx_hold_data(tx_data), .tx_hold_write(tx_wr),
      .rx_hold_read(rx_rd), .rx_error(rx_error), .rx_level(rx_level), .tx_level(tx_level),
      .rx_trigger(rx_trig), .tx_trigger(tx_trig), .rts_halt_level(halt),
      .rts_resume_level(resume), .channel_a_rx_dma_ready_n(rx_rdy_n),
      .channel_a_tx_dma_ready_n(tx_rdy_n));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (tx_wr === 1'b1) n_tx++;
      if (rx_rd === 1'b1) n_rd++;
      if (cycles == 20000) begin
         errors++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         errors++;
         $display("FAIL %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   task automatic t_reset();
      chk({irq_oe, user_n, rts_n, tx_pin, data_oe, tx_wr, rx_rdy_n, rx_bit},
         8'h73);
   endtask
   task automatic t_irq();
      host.put(`UCPC_OFS_MCR, 8'h08, 1'b0);
      step(3);
      chk(irq_oe, 1'b1);
      for (int i = 0; i < 4; i++) begin
         host.put(`UCPC_OFS_IER, 8'(1 << i), 1'b0);
         step(3);
         chk(irq, 1'b0);
         case (i)
            0: rx_level = 7'h01;
            1: tx_level = 7'h00;
            2: rx_error = 1'b1;
            default: begin
               ring_n = 1'b0;
               step(6);
               ring_n = 1'b1;
            end
         endcase
         step(8);
         chk(irq, 1'b1);
         host.put(`UCPC_OFS_IER, 8'h00, 1'b0);
         step(3);
         chk(irq, 1'b0);
         rx_level = 7'h00;
         tx_level = 7'h3C;
         rx_error = 1'b0;
      end
      host.get(`UCPC_OFS_MSR, got);
      chk({got[6], got[2]}, 8'h01);
      ring_n = 1'b0;
      step(6);
      host.get(`UCPC_OFS_MSR, got);
      chk({got[6], got[2]}, 8'h02);
      ring_n = 1'b1;
   endtask
   task automatic t_out();
      host.get(`UCPC_OFS_MCR, got);
      chk(got, 8'h08);
      chk({irq_oe, user_n}, 8'h02);
      host.put(`UCPC_OFS_MCR, 8'h00, 1'b0);
      step(2);
      chk({irq_oe, user_n}, 8'h01);
   endtask
   task automatic t_rts();
      host.put(`UCPC_OFS_MCR, 8'h02, 1'b0);
      step(2);
      chk(rts_n, 1'b0);
      host.put(`UCPC_OFS_EFR, 8'h40, 1'b0);
      rx_level = 7'h0A;
      step(4);
      chk(rts_n, 1'b1);
      rx_level = 7'h06;
      step(4);
      chk(rts_n, 1'b1);
      rx_level = 7'h04;
      step(4);
      chk(rts_n, 1'b0);
      rx_level = 7'h00;
      host.put(`UCPC_OFS_MCR, 8'h00, 1'b0);
      step(2);
      chk(rts_n, 1'b1);
      host.put(`UCPC_OFS_EFR, 8'h00, 1'b0);
   endtask
   task automatic t_loop();
      tx_bit = 1'b0;
      rx_pin = 1'b1;
      step(6);
      chk({tx_pin, rx_bit}, 8'h01);
      host.put(`UCPC_OFS_MCR, 8'h10, 1'b0);
      for (int b = 0; b < 2; b++) begin
         tx_bit = b[0];
         rx_pin = ~b[0];
         step(6);
         chk({tx_pin, rx_bit}, {6'h00, 1'b1, b[0]});
      end
      host.put(`UCPC_OFS_MCR, 8'h00, 1'b0);
   endtask
   task automatic t_dma();
      logic [6:0] lv[4];
      lv = '{7'h00, 7'h01, 7'h3C, 7'h38};
      for (int i = 0; i < 4; i++) begin
         rx_level = lv[i];
         tx_level = lv[i];
         step(3);
         chk({rx_rdy_n, tx_rdy_n}, {6'h00, i == 0, i == 2});
      end
      tx_level = 7'h40;
      rx_level = 7'h00;
      step(3);
      chk({rx_rdy_n, tx_rdy_n}, 8'h03);
   endtask
   task automatic t_cs();
      host.put(`UCPC_OFS_MCR, 8'h08, 1'b1);
      step(2);
      chk(user_n, 1'b1);
      n_tx = 0;
      host.put(`UCPC_OFS_DATA, 8'hA5, 1'b0);
      chk(n_tx[7:0], 8'h01);
      chk(tx_data, 8'hA5);
      n_rd = 0;
      host.get(`UCPC_OFS_DATA, got);
      chk(got, 8'h3C);
      chk(n_rd[7:0], 8'h01);
   endtask
   initial begin
      {errors, checks, cycles, n_tx, n_rd} = '0;
      rst = 1'b1;
      {ring_n, rx_pin, tx_bit, rx_error} = 4'hA;
      {rx_level, tx_level} = 14'h0;
      {rx_trig, tx_trig, halt, resume} = {7'h08, 7'h08, 7'h0A, 7'h04};
      rx_hold = 8'h3C;
      step(5);
      t_reset();
      step(1);
      rst = 1'b0;
      step(1);
      t_reset();
      tx_level = 7'h3C;
      t_irq();
      t_out();
      t_rts();
      t_loop();
      t_dma();
      t_cs();
      close_out();
   end
endmodule
